// file: pasc_regs.svh
`ifndef PASC_REGS_SVH
`define PASC_REGS_SVH

// ---------------------------------------------------------------------------
// Register numbers of the advanced bank
// ---------------------------------------------------------------------------
`define PASC_REG_STATUS1    4'h0
`define PASC_REG_STATUS2    4'h1
`define PASC_REG_GOOD_HIGH  4'h2
`define PASC_REG_GOOD_MID   4'h3
`define PASC_REG_GOOD_LOW   4'h4
`define PASC_REG_FCS_HIGH   4'h5
`define PASC_REG_FCS_MID    4'h6
`define PASC_REG_FCS_LOW    4'h7
`define PASC_REG_LAST       4'hc

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define PASC_S1_PLL_LOCK    15
`define PASC_S1_PAIR3       14
`define PASC_S1_PAIR0       11
`define PASC_S1_REFCLK      8
`define PASC_S2_XOVER_LOW   15
`define PASC_S2_XOVER_HIGH  14
`define PASC_S2_SPEEDOPT    13

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define PASC_WORD_RESET     16'h0000
`define PASC_COUNT_RESET    48'h0000_0000_0000

`endif

// file: pasc_pkg.sv
`default_nettype none

package pasc_pkg;

   typedef logic [15:0] pasc_word_t;
   typedef logic [47:0] pasc_count_t;

endpackage : pasc_pkg

`default_nettype wire

// file: pasc_bank.sv
`include "pasc_regs.svh"
`default_nettype none

module pasc_bank #(
   parameter int ADDR_W = 5
) (
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              resetn,
   // Address port write
   input  wire logic              addr_wr,
   input  wire logic              addr_rd_req,
   input  wire logic [ADDR_W-1:0] addr_reg,
   // Read data port
   input  wire logic              data_rd,
   output logic [15:0]            rd_data,
   output logic                   rd_valid,
   // Status sources
   input  wire logic              pll_lock_flag,
   input  wire logic              gig_mode,
   input  wire logic              pair3_reversed,
   input  wire logic              pair2_reversed,
   input  wire logic              pair1_reversed,
   input  wire logic              pair0_reversed,
   input  wire logic              refclk_freq_strap,
   input  wire logic              crossover_pairs_low,
   input  wire logic              crossover_pairs_high,
   input  wire logic              speedopt_link,
   // Counter events
   input  wire logic              good_rx_frame,
   input  wire logic              fcs_error
);

   initial begin
      if (ADDR_W < 4) begin
         $error("pasc_bank: ADDR_W must be at least 4");
      end
   end

   // ------------------------------------------------------------------------
   // Selected register number
   // ------------------------------------------------------------------------
   // The number is latched only when the read bit accompanies the write; a
   // write without it leaves the previous selection in place.
   logic [ADDR_W-1:0] sel_q;
   logic              sel_ok_q;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         sel_q    <= '0;
         sel_ok_q <= 1'b0;
      end else if (addr_wr && addr_rd_req) begin
         sel_q    <= addr_reg;
         sel_ok_q <= (addr_reg <= ADDR_W'(`PASC_REG_LAST));
      end
   end

   logic rd_good_high;
   logic rd_good_low;
   logic rd_fcs_high;
   logic rd_fcs_low;

   assign rd_good_high = data_rd && sel_ok_q
                         && sel_q == ADDR_W'(`PASC_REG_GOOD_HIGH);
   assign rd_good_low  = data_rd && sel_ok_q
                         && sel_q == ADDR_W'(`PASC_REG_GOOD_LOW);
   assign rd_fcs_high  = data_rd && sel_ok_q
                         && sel_q == ADDR_W'(`PASC_REG_FCS_HIGH);
   assign rd_fcs_low   = data_rd && sel_ok_q
                         && sel_q == ADDR_W'(`PASC_REG_FCS_LOW);

   // ------------------------------------------------------------------------
   // Status words
   // ------------------------------------------------------------------------
   pasc_pkg::pasc_word_t status1_q;
   pasc_pkg::pasc_word_t status2_q;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         status1_q <= `PASC_WORD_RESET;
      end else begin
         status1_q <= `PASC_WORD_RESET;
         status1_q[`PASC_S1_PLL_LOCK] <= pll_lock_flag;
         // Polarity only means something in gigabit operation.
         status1_q[`PASC_S1_PAIR3:`PASC_S1_PAIR0] <= gig_mode ?
            {pair3_reversed, pair2_reversed,
             pair1_reversed, pair0_reversed} : 4'h0;
         status1_q[`PASC_S1_REFCLK] <= refclk_freq_strap;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         status2_q <= `PASC_WORD_RESET;
      end else begin
         status2_q <= `PASC_WORD_RESET;
         status2_q[`PASC_S2_XOVER_LOW]  <= crossover_pairs_low;
         status2_q[`PASC_S2_XOVER_HIGH] <= crossover_pairs_high;
         status2_q[`PASC_S2_SPEEDOPT]   <= speedopt_link;
      end
   end

   // ------------------------------------------------------------------------
   // Counters
   // ------------------------------------------------------------------------
   // A count that lands in the clearing cycle is kept as one, so no event is
   // lost. Counters saturate rather than wrap; at one frame per cycle the
   // 48 bits last for days, so the cost of the compare is worth it.
   pasc_pkg::pasc_count_t good_rx_frame_count_q;
   pasc_pkg::pasc_count_t fcs_error_count_q;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         good_rx_frame_count_q <= `PASC_COUNT_RESET;
      end else if (rd_good_high) begin
         good_rx_frame_count_q <= {47'h0, good_rx_frame};
      end else if (good_rx_frame && ~&good_rx_frame_count_q) begin
         good_rx_frame_count_q <= good_rx_frame_count_q + 48'h1;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         fcs_error_count_q <= `PASC_COUNT_RESET;
      end else if (rd_fcs_high) begin
         fcs_error_count_q <= {47'h0, fcs_error};
      end else if (fcs_error && ~&fcs_error_count_q) begin
         fcs_error_count_q <= fcs_error_count_q + 48'h1;
      end
   end

   // ------------------------------------------------------------------------
   // Snapshots of the upper words
   // ------------------------------------------------------------------------
   // Reading a low word freezes middle and high so that the ordered read
   // returns one coherent 48-bit value even while frames keep arriving.
   logic [31:0] good_snap_q;
   logic [31:0] fcs_snap_q;

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         good_snap_q <= 32'h0;
      end else if (rd_good_low) begin
         good_snap_q <= good_rx_frame_count_q[47:16];
      end else if (rd_good_high) begin
         good_snap_q <= 32'h0;
      end
   end

   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         fcs_snap_q <= 32'h0;
      end else if (rd_fcs_low) begin
         fcs_snap_q <= fcs_error_count_q[47:16];
      end else if (rd_fcs_high) begin
         fcs_snap_q <= 32'h0;
      end
   end

   // ------------------------------------------------------------------------
   // Read data port
   // ------------------------------------------------------------------------
   pasc_pkg::pasc_word_t rd_mux;

   always_comb begin
      rd_mux = `PASC_WORD_RESET;
      if (sel_ok_q) begin
         case (sel_q[3:0])
            `PASC_REG_STATUS1:   rd_mux = status1_q;
            `PASC_REG_STATUS2:   rd_mux = status2_q;
            `PASC_REG_GOOD_HIGH: rd_mux = good_snap_q[31:16];
            `PASC_REG_GOOD_MID:  rd_mux = good_snap_q[15:0];
            `PASC_REG_GOOD_LOW:  rd_mux = good_rx_frame_count_q[15:0];
            `PASC_REG_FCS_HIGH:  rd_mux = fcs_snap_q[31:16];
            `PASC_REG_FCS_MID:   rd_mux = fcs_snap_q[15:0];
            `PASC_REG_FCS_LOW:   rd_mux = fcs_error_count_q[15:0];
            default:             rd_mux = `PASC_WORD_RESET;
         endcase
      end
   end

   // There is no write path to any of these words at all.
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         rd_data  <= `PASC_WORD_RESET;
         rd_valid <= 1'b0;
      end else begin
         rd_valid <= data_rd;
         if (data_rd) begin
            rd_data <= rd_mux;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------------------
   a_read_answers: assert property (@(posedge core_clk) disable iff (!resetn)
      data_rd |=> rd_valid && rd_data == $past(rd_mux))
      else $error("read data port did not answer with selected word");

   a_good_clear: assert property (@(posedge core_clk) disable iff (!resetn)
      rd_good_high |=> good_rx_frame_count_q <= 48'h1)
      else $error("good frame counter not cleared by high read");

   a_fcs_clear: assert property (@(posedge core_clk) disable iff (!resetn)
      rd_fcs_high |=> fcs_error_count_q <= 48'h1)
      else $error("crc error counter not cleared by high read");

   a_good_count: assert property (@(posedge core_clk) disable iff (!resetn)
      good_rx_frame && !rd_good_high && !(&good_rx_frame_count_q)
      |=> good_rx_frame_count_q == $past(good_rx_frame_count_q) + 48'h1)
      else $error("good frame not counted");

   a_fcs_count: assert property (@(posedge core_clk) disable iff (!resetn)
      fcs_error && !rd_fcs_high && !(&fcs_error_count_q)
      |=> fcs_error_count_q == $past(fcs_error_count_q) + 48'h1)
      else $error("crc error not counted");

   a_pll_bit: assert property (@(posedge core_clk) disable iff (!resetn)
      ##1 status1_q[`PASC_S1_PLL_LOCK] == $past(pll_lock_flag))
      else $error("pll lock bit does not follow lock");

   a_status_reserved: assert property (@(posedge core_clk)
      disable iff (!resetn)
      status1_q[10:9] == 2'h0 && status1_q[7:0] == 8'h0
      && status2_q[12:0] == 13'h0)
      else $error("reserved status bits not zero");

   a_snap_coherent: assert property (@(posedge core_clk) disable iff (!resetn)
      rd_good_low ##1 !rd_good_low && !rd_good_high
      |-> good_snap_q == $past(good_rx_frame_count_q[47:16]))
      else $error("snapshot differs from count at low read");

   a_xover_bits: assert property (@(posedge core_clk) disable iff (!resetn)
      ##1 status2_q[15:13] == $past({crossover_pairs_low,
                                     crossover_pairs_high,
                                     speedopt_link}))
      else $error("crossover or speed optimiser bits wrong");

   // ------------------------------------------------------------------------
   // Side effects and holding
   // ------------------------------------------------------------------------
   // These checks pin down the remaining status bits and what the read port does between reads, since a
   // stray clear or a moving word would corrupt the ordered counter read.
   // Set-wins at a clear is checked too, as a lost frame would go unseen.
   a_refclk_bit: assert property (@(posedge core_clk) disable iff (!resetn)
      ##1 status1_q[`PASC_S1_REFCLK] == $past(refclk_freq_strap))
      else $error("reference clock bit does not follow strap");

   a_polarity_bits: assert property (@(posedge core_clk)
      disable iff (!resetn)
      ##1 status1_q[14:11] == ($past({pair3_reversed, pair2_reversed,
         pair1_reversed, pair0_reversed}) & {4{$past(gig_mode)}}))
      else $error("polarity bits wrong");

   a_fcs_snap_coherent: assert property (@(posedge core_clk)
      disable iff (!resetn)
      rd_fcs_low ##1 !rd_fcs_low && !rd_fcs_high
      |-> fcs_snap_q == $past(fcs_error_count_q[47:16]))
      else $error("crc snapshot differs from count at low read");

   a_valid_pulse: assert property (@(posedge core_clk) disable iff (!resetn)
      !data_rd |=> !rd_valid)
      else $error("read valid without a read");

   a_data_holds: assert property (@(posedge core_clk) disable iff (!resetn)
      !data_rd |=> $stable(rd_data))
      else $error("read data changed without a read");

   a_sel_ignored: assert property (@(posedge core_clk) disable iff (!resetn)
      addr_wr && !addr_rd_req |=> $stable(sel_q))
      else $error("selection changed without read bit");

   a_sel_taken: assert property (@(posedge core_clk) disable iff (!resetn)
      addr_wr && addr_rd_req |=> sel_q == $past(addr_reg))
      else $error("selection not taken from address write");

   a_unmapped_zero: assert property (@(posedge core_clk) disable iff (!resetn)
      !sel_ok_q |-> rd_mux == 16'h0000)
      else $error("unmapped register number did not read zero");

   a_good_saturate: assert property (@(posedge core_clk)
      disable iff (!resetn)
      good_rx_frame && !rd_good_high && (&good_rx_frame_count_q)
      |=> &good_rx_frame_count_q)
      else $error("good frame counter wrapped");

   a_fcs_saturate: assert property (@(posedge core_clk)
      disable iff (!resetn)
      fcs_error && !rd_fcs_high && (&fcs_error_count_q)
      |=> &fcs_error_count_q)
      else $error("crc error counter wrapped");

   a_good_clear_event: assert property (@(posedge core_clk)
      disable iff (!resetn)
      rd_good_high && good_rx_frame
      |=> good_rx_frame_count_q == 48'h1)
      else $error("frame lost at good counter clear");

   a_fcs_clear_event: assert property (@(posedge core_clk)
      disable iff (!resetn)
      rd_fcs_high && fcs_error
      |=> fcs_error_count_q == 48'h1)
      else $error("error lost at crc counter clear");

   a_good_snap_clear: assert property (@(posedge core_clk)
      disable iff (!resetn)
      rd_good_high
      |=> good_snap_q == 32'h0)
      else $error("good snapshot not cleared by high read");

   a_fcs_snap_clear: assert property (@(posedge core_clk)
      disable iff (!resetn)
      rd_fcs_high
      |=> fcs_snap_q == 32'h0)
      else $error("crc snapshot not cleared by high read");

   a_good_idle: assert property (@(posedge core_clk)
      disable iff (!resetn)
      !good_rx_frame && !rd_good_high
      |=> $stable(good_rx_frame_count_q))
      else $error("good frame counter moved without cause");

   a_fcs_idle: assert property (@(posedge core_clk)
      disable iff (!resetn)
      !fcs_error && !rd_fcs_high
      |=> $stable(fcs_error_count_q))
      else $error("crc error counter moved without cause");

endmodule : pasc_bank

`default_nettype wire

// file: phy_advanced_status_counters_tb.sv
`default_nettype none

module phy_advanced_status_counters_tb;
   timeunit 1ns;
   timeprecision 1ps;

   // ------------------------------------------------------------------------
   // Stimulus and observation
   // ------------------------------------------------------------------------
   logic                core_clk;
   logic                resetn;
   logic                addr_wr;
   logic                addr_rd_req;
   logic [4:0]          addr_reg;
   logic                data_rd;
   pasc_pkg::pasc_word_t rd_data;
   logic                rd_valid;
   logic [9:0]          st;
   logic                good_rx_frame;
   logic                fcs_error;
   int                  n_fail;
   int                  compares;
   pasc_pkg::pasc_word_t v;
   pasc_pkg::pasc_count_t ng;
   pasc_pkg::pasc_count_t nf;

   pasc_bank #(.ADDR_W(5)) i_pasc_bank (
      .core_clk(core_clk), .resetn(resetn), .addr_wr(addr_wr),
      .addr_rd_req(addr_rd_req), .addr_reg(addr_reg), .data_rd(data_rd),
      .rd_data(rd_data), .rd_valid(rd_valid), .gig_mode(st[9]),
      .pll_lock_flag(st[8]), .pair3_reversed(st[7]),
      .pair2_reversed(st[6]), .pair1_reversed(st[5]),
      .pair0_reversed(st[4]), .refclk_freq_strap(st[3]),
      .crossover_pairs_low(st[2]), .crossover_pairs_high(st[1]),
      .speedopt_link(st[0]), .good_rx_frame(good_rx_frame),
      .fcs_error(fcs_error)
   );

   always #5 core_clk = ~core_clk;

   // ------------------------------------------------------------------------
   // Checking helpers
   // ------------------------------------------------------------------------
   function automatic pasc_pkg::pasc_word_t exp_s1(input logic [9:0] s);
      // Polarity flags only mean something in gigabit mode.
      exp_s1 = {s[8], s[7:4] & {4{s[9]}}, 2'h0, s[3], 8'h00};
   endfunction : exp_s1

   function automatic pasc_pkg::pasc_word_t exp_s2(input logic [9:0] s);
      exp_s2 = {s[2], s[1], s[0], 13'h0000};
   endfunction : exp_s2

   task automatic chk(input string nm, input logic [47:0] seen,
                      input logic [47:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : report_and_stop

   task automatic sel(input logic [4:0] r, input logic q);
      addr_wr     = 1'b1;
      addr_rd_req = q;
      addr_reg    = r;
      @(posedge core_clk);
      #1;
      addr_wr     = 1'b0;
   endtask : sel

   task automatic get(output pasc_pkg::pasc_word_t d);
      data_rd = 1'b1;
      @(posedge core_clk);
      #1;
      data_rd = 1'b0;
      chk("rd_valid_high", rd_valid, 1'b1);
      d = rd_data;
      @(posedge core_clk);
      #1;
      chk("rd_valid_low", rd_valid, 1'b0);
   endtask : get

   task automatic rd(input logic [4:0] r, output pasc_pkg::pasc_word_t d);
      sel(r, 1'b1);
      get(d);
   endtask : rd

   task automatic ev(input logic g, input logic f);
      good_rx_frame = g;
      fcs_error     = f;
      @(posedge core_clk);
      #1;
      good_rx_frame = 1'b0;
      fcs_error     = 1'b0;
   endtask : ev

   // Reads a counter low, mid, high; the high read clears it.
   task automatic cnt(input logic [4:0] lo, input pasc_pkg::pasc_count_t e);
      pasc_pkg::pasc_word_t d;
      rd(lo, d);
      chk("count_low", d, e[15:0]);
      rd(lo - 5'h01, d);
      chk("count_mid", d, e[31:16]);
      rd(lo - 5'h02, d);
      chk("count_high", d, e[47:32]);
   endtask : cnt

   // ------------------------------------------------------------------------
   // Test sequence
   // ------------------------------------------------------------------------
   initial begin
      core_clk = 1'b0; resetn = 1'b0; addr_wr = 1'b0; addr_rd_req = 1'b0;
      addr_reg = 5'h00; data_rd = 1'b0; st = 10'h000;
      good_rx_frame = 1'b0; fcs_error = 1'b0; n_fail = 0; compares = 0;
      void'($urandom(32'h8334));
      repeat (12) @(posedge core_clk);
      #1;
      resetn = 1'b1;
      for (int r = 0; r < 14; r++) begin
         rd((r == 13) ? 5'h1f : 5'(r), v);
         chk("reset_word", v, 16'h0000);
      end
      $display("test reset values done");
      for (int i = 0; i < 24; i++) begin
         st = (i == 0) ? 10'h3ff : (i == 1) ? 10'h1ff : 10'($urandom);
         repeat (3) @(posedge core_clk);
         #1;
         rd(5'h00, v);
         chk("status1", v, exp_s1(st));
         rd(5'h01, v);
         chk("status2", v, exp_s2(st));
         sel(5'h02, 1'b0);
         get(v);
         chk("ignored_select", v, exp_s2(st));
      end
      $display("test status words done");
      for (int k = 0; k < 4; k++) begin
         ng = '0;
         nf = '0;
         for (int c = $urandom_range(60, 5); c > 0; c--) begin
            good_rx_frame = 1'($urandom);
            fcs_error     = (k == 3) ? 1'b1 : 1'($urandom);
            ng += 48'(good_rx_frame);
            nf += 48'(fcs_error);
            @(posedge core_clk);
            #1;
         end
         good_rx_frame = 1'b0;
         fcs_error     = 1'b0;
         cnt(5'h04, ng);
         cnt(5'h07, nf);
         rd(5'h04, v);
         repeat (3) ev(1'b1, 1'b0);
         rd(5'h03, v);
         chk("snap_mid", v, 16'h0000);
         rd(5'h02, v);
         chk("snap_high", v, 16'h0000);
         cnt(5'h04, 48'h0);
         cnt(5'h07, 48'h0);
      end
      $display("test counters done");
      report_and_stop();
   end

   initial begin
      #400000;
      n_fail++;
      report_and_stop();
   end

endmodule : phy_advanced_status_counters_tb

`default_nettype wire
